// ---- bench/tb.sv ----
// Self-checking bench for the turns and angle readout
`timescale 1ns/1ps
module tb import tcar_pkg::*;;
    logic clock = 1'b0, rst = 1'b1, angleUpdate = 1'b0, overflowClear = 1'b0;
    logic turnSourceSelect = 1'b0, eighthTurnResolution = 1'b0, readStrobe, readValid;
    logic turnOverflowFlag, errorSummaryFlag, undervoltageFlag, ovf = 1'b0, held = 1'b0;
    logic [7:0]   readAddr;
    tcar_word_t   readData;
    tcar_angles_t angles = '0;
    tcar_flags_t  flags = '0;
    integer failures = 0, checksDone = 0, cycles = 0, tot = 0, prev = 0, refOk = 0, low = 0;
    tcar_turns_readout DUT (.clock(clock), .rst(rst), .angles(angles),
        .angleUpdate(angleUpdate), .flags(flags), .turnSourceSelect(turnSourceSelect),
        .eighthTurnResolution(eighthTurnResolution), .overflowClear(overflowClear),
        .readStrobe(readStrobe), .readAddr(readAddr), .readData(readData),
        .readValid(readValid), .turnOverflowFlag(turnOverflowFlag),
        .errorSummaryFlag(errorSummaryFlag), .undervoltageFlag(undervoltageFlag));
    tcar_host_model host (.clock(clock), .readData(readData), .readValid(readValid),
        .readStrobe(readStrobe), .readAddr(readAddr));
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    function automatic tcar_word_t par(input tcar_word_t w);
        par     = w;
        par[12] = ~^{w[15:13], w[11:0]};
    endfunction
    function automatic logic errExp();
        errExp = |(flags.fault & ~flags.faultMask) | |(flags.caution & ~flags.cautionMask);
    endfunction
    function automatic logic uvExp();
        uvExp = (flags.analogLow & ~flags.analogMask) | (flags.digitalLow & ~flags.digitalMask);
    endfunction
    task automatic cmpw(input tcar_word_t g, input tcar_word_t e);
        checksDone++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmpb(input logic g, input logic e);
        cmpw({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic rdchk(input logic [7:0] a, input tcar_word_t e);
        tcar_word_t d;
        logic v;
        host.rd(a, d, v);
        cmpb(v, 1'b1);
        cmpw(d, e);
    endtask
    task automatic rdTurn();
        logic [20:0] t;
        t = tot[20:0];
        low = eighthTurnResolution ? tot & 32'h0000_01FF : tot & 32'h0000_07FF;
        rdchk(8'h2C, par({2'b11, turnSourceSelect, 1'b0, eighthTurnResolution ?
            t[20:9] : {{2{t[20]}}, t[20:11]}}));
        held = 1'b1;
    endtask
    task automatic rdPair();
        tcar_word_t d1, d2, e1;
        logic [20:0] t;
        t = tot[20:0];
        low = eighthTurnResolution ? tot & 32'h0000_01FF : tot & 32'h0000_07FF;
        e1 = par({2'b11, turnSourceSelect, 1'b0,
            eighthTurnResolution ? t[20:9] : {{2{t[20]}}, t[20:11]}});
        host.rd2(8'h2C, 8'h2E, d1, d2);
        cmpw(d1, e1);
        cmpw(d2, par({1'b1, 1'b1, 3'b000, low[10:0]}));
        held = 1'b0;
    endtask
    task automatic rdLow();
        rdchk(8'h2E, par({1'b1, held, 3'b000, low[10:0]}));
        held = 1'b0;
    endtask
    task automatic step(input integer d);
        integer n, df;
        n = (prev + d) & 4095;
        @(posedge clock) #1;
        angleUpdate      = 1'b1;
        angles.pllTurn   = turnSourceSelect ? n[11:0] : ~n[11:0];
        angles.crossing  = turnSourceSelect ? ~n[11:0] : n[11:0];
        @(posedge clock) #1;
        angleUpdate = 1'b0;
        df = ((n - prev + 2048) & 4095) - 2048;
        if (refOk == 0) refOk = 1;
        else if (tot + df > 1048575 || tot + df < -1048576) ovf = 1'b1;
        else tot = tot + df;
        prev = n;
        @(posedge clock) #1;
        cmpb(turnOverflowFlag, ovf);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(88751));
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        for (int s = 0; s < 2; s++) begin
            turnSourceSelect = s[0];
            rdTurn();
        end
        rdLow();
        rdchk(8'h2D, 16'h0000);
        turnSourceSelect = $urandom % 2;
        repeat (40) step(int'($urandom % 3001) - 1500);
        for (int m = 0; m < 2; m++) begin
            eighthTurnResolution = m[0];
            rdTurn();
            step(777);
            rdLow();
            rdLow();
            rdPair();
        end
        repeat (8) begin
            flags = {$urandom, $urandom, 4'($urandom)};
            flags.fault   = 16'h0001 << ($urandom % 16);
            flags.caution = 16'h0001 << ($urandom % 16);
            angles        = {19'($urandom), $urandom};
            #1 cmpb(errorSummaryFlag, errExp());
            cmpb(undervoltageFlag, uvExp());
            rdchk(8'h30, par({1'b0, errExp(), uvExp(), 1'b0, angles.hysteresis}));
            rdchk(8'h32, {1'b0, angles.fine});
            rdchk(8'h34, par({1'b0, errExp(), uvExp(), 1'b0, angles.crossing}));
        end
        repeat (560) step(2000);
        rdTurn();
        @(posedge clock) #1 overflowClear = 1'b1;
        @(posedge clock) #1 overflowClear = 1'b0;
        ovf = 1'b0;
        @(posedge clock) #1 cmpb(turnOverflowFlag, 1'b0);
        eighthTurnResolution = 1'b0;
        repeat (1100) step(-2000);
        rdTurn();
        rdLow();
        tally_and_finish();
    end
endmodule // tb

// ---- bench/tcar_host_model.sv ----
// Host side model that issues single register reads and back-to-back read pairs
`timescale 1ns/1ps
module tcar_host_model
    import tcar_pkg::*;
(
    input  wire logic       clock,
    input  wire tcar_word_t readData,
    input  wire logic       readValid,
    output logic            readStrobe,
    output logic [7:0]      readAddr
);
    initial begin
        readStrobe = 1'b0;
        readAddr   = 8'h00;
    end
    // Address goes to its inverse when released so a stale decode cannot pass
    task automatic rd(input logic [7:0] a, output tcar_word_t d, output logic v);
        @(posedge clock) #1;
        readStrobe = 1'b1;
        readAddr   = a;
        @(posedge clock) #1;
        readStrobe = 1'b0;
        readAddr   = ~a;
        d          = readData;
        v          = readValid;
    endtask
    // Two reads on consecutive edges, strobe held high between them
    task automatic rd2(input logic [7:0] a, input logic [7:0] b,
                       output tcar_word_t d1, output tcar_word_t d2);
        @(posedge clock) #1;
        readStrobe = 1'b1;
        readAddr   = a;
        @(posedge clock) #1;
        readAddr   = b;
        d1         = readData;
        @(posedge clock) #1;
        readStrobe = 1'b0;
        readAddr   = ~b;
        d2         = readData;
    endtask
endmodule // tcar_host_model

// ---- design/tcar_parity_word.sv ----
// Inserts the odd parity bit into one readout word
`timescale 1ns/1ps
`include "tcar_regs.svh"

module tcar_parity_word
    import tcar_pkg::*;
(
    input  wire tcar_word_t rawWord,
    output tcar_word_t      packedWord
);
    wire tcar_word_t cleared = rawWord & ~(tcar_word_t'(1) << `TCAR_BIT_PARITY);
    wire             oddBit  = ~(^cleared);

    always_comb begin
        packedWord = cleared;
        packedWord[`TCAR_BIT_PARITY] = oddBit;
    end
endmodule // tcar_parity_word

// ---- design/tcar_pkg.sv ----
// Types shared by the turns and angle readout files
package tcar_pkg;
    typedef logic [15:0] tcar_word_t;

    typedef struct packed {
        logic [11:0] pllTurn;
        logic [11:0] crossing;
        logic [11:0] hysteresis;
        logic [14:0] fine;
    } tcar_angles_t;

    typedef struct packed {
        logic [15:0] fault;
        logic [15:0] caution;
        logic [15:0] faultMask;
        logic [15:0] cautionMask;
        logic        analogLow;
        logic        digitalLow;
        logic        analogMask;
        logic        digitalMask;
    } tcar_flags_t;
endpackage

// ---- design/tcar_regs.svh ----
// Register offsets, field positions and reset values of the turns and angle readout
`ifndef TCAR_REGS_SVH
`define TCAR_REGS_SVH

`define TCAR_OFF_TURN_COUNT    8'h2C
`define TCAR_OFF_TURN_LOW      8'h2E
`define TCAR_OFF_HYST_ANGLE    8'h30
`define TCAR_OFF_FINE_ANGLE    8'h32
`define TCAR_OFF_CROSS_ANGLE   8'h34

`define TCAR_BIT_ID_HI         15
`define TCAR_BIT_ID_LO         14
`define TCAR_BIT_HELD          14
`define TCAR_BIT_ERROR         14
`define TCAR_BIT_SOURCE        13
`define TCAR_BIT_UNDERVOLT     13
`define TCAR_BIT_PARITY        12

`define TCAR_ID_TURN_COUNT     2'h3
`define TCAR_ID_TURN_LOW       1'h1

`define TCAR_TOTAL_RST         21'h0_0000
`define TCAR_ANGLE_RST         12'h000
`define TCAR_LOW_RST           11'h000
`define TCAR_WORD_RST          16'h0000

`define TCAR_PARITY_WORDS      4
`define TCAR_PW_TURN           0
`define TCAR_PW_LOW            1
`define TCAR_PW_HYST           2
`define TCAR_PW_CROSS          3

`endif

// ---- design/tcar_turns_readout.sv ----
// Multi-turn counter and angle readout registers of the angle sensor
`timescale 1ns/1ps
`include "tcar_regs.svh"

module tcar_turns_readout
    import tcar_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire tcar_angles_t angles,
    input  wire logic         angleUpdate,
    input  wire tcar_flags_t  flags,
    input  wire logic         turnSourceSelect,
    input  wire logic         eighthTurnResolution,
    input  wire logic         overflowClear,
    input  wire logic         readStrobe,
    input  wire logic [7:0]   readAddr,
    output tcar_word_t        readData,
    output logic              readValid,
    output logic              turnOverflowFlag,
    output logic              errorSummaryFlag,
    output logic              undervoltageFlag
);
    logic signed [20:0] turnTotal_reg;
    logic signed [20:0] turnTotal_next;
    logic [11:0]        lastAngle_reg;
    logic               refValid_reg;
    logic [10:0]        lowCapture_reg;
    logic               held_reg;
    logic               overflow_reg;
    tcar_word_t         readData_reg;
    tcar_word_t         readData_next;
    logic               readValid_reg;
    logic [7:0]         lastAddr_reg;

    // Angle that feeds the counter follows the selected path
    wire [11:0] countAngle = turnSourceSelect ? angles.pllTurn : angles.crossing;
    // A wrapped 12-bit difference is the shortest way round the circle
    wire [11:0]        stepRaw  = countAngle - lastAngle_reg;
    wire signed [21:0] stepWide = {{10{stepRaw[11]}}, stepRaw};
    wire signed [21:0] sumWide  = {turnTotal_reg[20], turnTotal_reg} + stepWide;
    wire               sumOvf   = sumWide[21] != sumWide[20];
    wire               doStep   = angleUpdate && refValid_reg;

    wire [11:0] turnField = eighthTurnResolution ? turnTotal_reg[20:9]
                          : {{2{turnTotal_reg[20]}}, turnTotal_reg[20:11]};
    wire [10:0] lowField  = eighthTurnResolution ? {2'b00, turnTotal_reg[8:0]}
                          : turnTotal_reg[10:0];

    wire readTurn  = readStrobe && (readAddr == `TCAR_OFF_TURN_COUNT);
    wire readLow   = readStrobe && (readAddr == `TCAR_OFF_TURN_LOW);
    wire readHyst  = readStrobe && (readAddr == `TCAR_OFF_HYST_ANGLE);
    wire readFine  = readStrobe && (readAddr == `TCAR_OFF_FINE_ANGLE);
    wire readCross = readStrobe && (readAddr == `TCAR_OFF_CROSS_ANGLE);

    wire errNow = |((flags.fault & ~flags.faultMask)
                    | (flags.caution & ~flags.cautionMask));
    wire uvNow  = (flags.analogLow & ~flags.analogMask)
                | (flags.digitalLow & ~flags.digitalMask);

    tcar_word_t rawWords [`TCAR_PARITY_WORDS];
    tcar_word_t parWords [`TCAR_PARITY_WORDS];

    assign rawWords[`TCAR_PW_TURN]  = {`TCAR_ID_TURN_COUNT, turnSourceSelect, 1'b0, turnField};
    assign rawWords[`TCAR_PW_LOW]   = {`TCAR_ID_TURN_LOW, held_reg, 2'b00, 1'b0,
                                       lowCapture_reg};
    assign rawWords[`TCAR_PW_HYST]  = {1'b0, errNow, uvNow, 1'b0, angles.hysteresis};
    assign rawWords[`TCAR_PW_CROSS] = {1'b0, errNow, uvNow, 1'b0, angles.crossing};

    genvar gi;
    generate
        for (gi = 0; gi < `TCAR_PARITY_WORDS; gi++) begin : g_par
            tcar_parity_word u_par (
                .rawWord    (rawWords[gi]),
                .packedWord (parWords[gi])
            );
        end
    endgenerate

    wire tcar_word_t fineWord = {1'b0, angles.fine};

    // Unmapped addresses answer with an all-zero word
    assign readData_next = readTurn  ? parWords[`TCAR_PW_TURN]
                         : readLow   ? parWords[`TCAR_PW_LOW]
                         : readHyst  ? parWords[`TCAR_PW_HYST]
                         : readFine  ? fineWord
                         : readCross ? parWords[`TCAR_PW_CROSS]
                         : `TCAR_WORD_RST;

    // Overflow holds the count at its last legal value instead of wrapping round
    assign turnTotal_next = (doStep && !sumOvf) ? sumWide[20:0] : turnTotal_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            turnTotal_reg <= `TCAR_TOTAL_RST;
            lastAngle_reg <= `TCAR_ANGLE_RST;
            refValid_reg  <= 1'b0;
        end else begin
            turnTotal_reg <= turnTotal_next;
            if (angleUpdate) begin
                lastAngle_reg <= countAngle;
                refValid_reg  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lowCapture_reg <= `TCAR_LOW_RST;
            held_reg       <= 1'b0;
        end else if (readTurn) begin
            lowCapture_reg <= lowField;
            held_reg       <= 1'b1;
        end else if (readLow) begin
            held_reg       <= 1'b0;
        end
    end

    // A new overflow wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            overflow_reg <= 1'b0;
        end else if (doStep && sumOvf) begin
            overflow_reg <= 1'b1;
        end else if (overflowClear) begin
            overflow_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            readData_reg  <= `TCAR_WORD_RST;
            readValid_reg <= 1'b0;
            lastAddr_reg  <= `TCAR_OFF_TURN_COUNT;
        end else begin
            readData_reg  <= readData_next;
            readValid_reg <= readStrobe;
            lastAddr_reg  <= readAddr;
        end
    end

    assign readData         = readData_reg;
    assign readValid        = readValid_reg;
    assign turnOverflowFlag = overflow_reg;
    assign errorSummaryFlag = errNow;
    assign undervoltageFlag = uvNow;

    wire lastTurn  = readValid_reg && (lastAddr_reg == `TCAR_OFF_TURN_COUNT);
    wire lastLow   = readValid_reg && (lastAddr_reg == `TCAR_OFF_TURN_LOW);
    wire lastFine  = readValid_reg && (lastAddr_reg == `TCAR_OFF_FINE_ANGLE);
    wire lastAngle = readValid_reg && ((lastAddr_reg == `TCAR_OFF_HYST_ANGLE)
                                    || (lastAddr_reg == `TCAR_OFF_CROSS_ANGLE));

    AST_ID_BITS: assert property (@(posedge clock) disable iff (rst)
        (lastTurn |-> readData[15:14] == 2'b11) and (lastLow |-> readData[15]))
        else $error("turn word identifier bits wrong");

    AST_OVERFLOW_SET: assert property (@(posedge clock) disable iff (rst)
        (doStep && sumOvf) |=> turnOverflowFlag && $stable(turnTotal_reg))
        else $error("overflow not flagged or count moved");

    AST_ODD_PARITY: assert property (@(posedge clock) disable iff (rst)
        (lastTurn || lastLow || lastAngle) |-> ^readData)
        else $error("readout word parity not odd");

    AST_START_ZERO: assert property (@(posedge clock)
        $fell(rst) |-> turnTotal_reg == 21'sd0)
        else $error("turn total not zero after reset");

    AST_EIGHTH_FIELD: assert property (@(posedge clock) disable iff (rst)
        (readTurn && eighthTurnResolution) |=> readData[11:0] == $past(turnTotal_reg[20:9]))
        else $error("eighth mode turn field wrong");

    AST_HALF_FIELD: assert property (@(posedge clock) disable iff (rst)
        (readTurn && !eighthTurnResolution)
        |=> readData[11:0] == {{2{$past(turnTotal_reg[20])}}, $past(turnTotal_reg[20:11])})
        else $error("half mode turn field wrong");

    AST_CAPTURE: assert property (@(posedge clock) disable iff (rst)
        readTurn ##1 (readStrobe && readAddr == `TCAR_OFF_TURN_LOW)
        |=> readData[10:0] == $past(lowField, 2) && readData[14])
        else $error("low bits not captured with turn count");

    AST_HELD_CLEAR: assert property (@(posedge clock) disable iff (rst)
        (readLow && !readTurn) |=> ##1 !held_reg || $past(readTurn))
        else $error("held bit did not clear after low read");

    AST_LOW_WIDTH: assert property (@(posedge clock) disable iff (rst)
        (readTurn && eighthTurnResolution) |=> lowCapture_reg[10:9] == 2'b00)
        else $error("eighth mode low field too wide");

    AST_FLAG_BITS: assert property (@(posedge clock) disable iff (rst)
        readHyst |=> readData[14] == $past(errNow) && readData[13] == $past(uvNow))
        else $error("angle word flag bits wrong");

    AST_FINE_TOP: assert property (@(posedge clock) disable iff (rst)
        lastFine |-> !readData[15])
        else $error("fine angle top bit set");

    AST_SOURCE_BIT: assert property (@(posedge clock) disable iff (rst)
        readTurn |=> readData[13] == $past(turnSourceSelect))
        else $error("turn source bit wrong");

    AST_HOLD_LOW: assert property (@(posedge clock) disable iff (rst)
        !readTurn |=> $stable(lowCapture_reg))
        else $error("captured low bits changed without turn read");

    // Reset must leave every visible state at its idle value
    AST_RESET_CLEAR: assert property (@(posedge clock)
        rst |=> readData == 16'h0000 && !readValid && !turnOverflowFlag && !held_reg)
        else $error("state not cleared by reset");

    // First sample after reset only sets the reference, so it must not count
    AST_REF_FIRST: assert property (@(posedge clock) disable iff (rst)
        (angleUpdate && !refValid_reg) |=> $stable(turnTotal_reg))
        else $error("first angle sample moved the turn total");

    AST_STEP_ADD: assert property (@(posedge clock) disable iff (rst)
        (doStep && !sumOvf) |=> turnTotal_reg == $past(turnTotal_reg) + $past(stepWide[20:0]))
        else $error("turn total did not add the angle step");

    AST_STEP_ONLY: assert property (@(posedge clock) disable iff (rst)
        !doStep |=> $stable(turnTotal_reg))
        else $error("turn total moved without an angle update");

    AST_OVERFLOW_STICKY: assert property (@(posedge clock) disable iff (rst)
        (turnOverflowFlag && !overflowClear) |=> turnOverflowFlag)
        else $error("overflow flag dropped without a clear");

    AST_OVERFLOW_CLEAR: assert property (@(posedge clock) disable iff (rst)
        (overflowClear && !(doStep && sumOvf)) |=> !turnOverflowFlag)
        else $error("overflow flag not cleared");

    // Holding the last legal value keeps the total inside the signed range instead of wrapping
    AST_NO_WRAP: assert property (@(posedge clock) disable iff (rst)
        (doStep && sumOvf) |=> turnTotal_reg == $past(turnTotal_reg))
        else $error("turn total wrapped on overflow");

    AST_HELD_SET: assert property (@(posedge clock) disable iff (rst)
        readTurn |=> held_reg)
        else $error("held bit not set by turn count read");

    AST_HELD_DROP: assert property (@(posedge clock) disable iff (rst)
        (readLow && !readTurn) |=> !held_reg)
        else $error("held bit not cleared by low read");

    AST_TURN_ANSWER: assert property (@(posedge clock) disable iff (rst)
        readTurn |=> lastTurn)
        else $error("turn count read not answered next cycle");

    AST_LOW_HALF: assert property (@(posedge clock) disable iff (rst)
        (readTurn && !eighthTurnResolution) |=> lowCapture_reg == $past(turnTotal_reg[10:0]))
        else $error("half mode low field wrong");

    AST_LOW_EIGHTH: assert property (@(posedge clock) disable iff (rst)
        (readTurn && eighthTurnResolution) |=> lowCapture_reg[8:0] == $past(turnTotal_reg[8:0]))
        else $error("eighth mode low field wrong");

    // Flag checks work group by group (fault, caution, undervoltage) so they do not repeat the reduction above
    AST_FAULT_FLAG: assert property (@(posedge clock) disable iff (rst)
        ((flags.fault & ~flags.faultMask) != 16'h0000) |-> errorSummaryFlag)
        else $error("unmasked fault not summarised");

    AST_CAUTION_FLAG: assert property (@(posedge clock) disable iff (rst)
        ((flags.caution & ~flags.cautionMask) != 16'h0000) |-> errorSummaryFlag)
        else $error("unmasked caution not summarised");

    AST_UV_FLAG: assert property (@(posedge clock) disable iff (rst)
        ((flags.analogLow && !flags.analogMask) || (flags.digitalLow && !flags.digitalMask))
        == undervoltageFlag)
        else $error("undervoltage flag wrong");

    AST_CROSS_FLAGS: assert property (@(posedge clock) disable iff (rst)
        readCross |=> readData[14] == $past(errNow) && readData[13] == $past(uvNow))
        else $error("crossing word flag bits wrong");

    AST_HYST_FIELD: assert property (@(posedge clock) disable iff (rst)
        readHyst |=> readData[11:0] == $past(angles.hysteresis) && !readData[15])
        else $error("hysteresis angle word wrong");

    AST_FINE_FIELD: assert property (@(posedge clock) disable iff (rst)
        readFine |=> readData[14:0] == $past(angles.fine))
        else $error("fine angle word wrong");

    AST_CROSS_FIELD: assert property (@(posedge clock) disable iff (rst)
        readCross |=> readData[11:0] == $past(angles.crossing) && !readData[15])
        else $error("crossing angle word wrong");

    // Reference must follow whichever path the source bit selects
    AST_SOURCE_PLL: assert property (@(posedge clock) disable iff (rst)
        (angleUpdate && turnSourceSelect) |=> lastAngle_reg == $past(angles.pllTurn))
        else $error("counter not fed from locked path");

    AST_SOURCE_CROSS: assert property (@(posedge clock) disable iff (rst)
        (angleUpdate && !turnSourceSelect) |=> lastAngle_reg == $past(angles.crossing))
        else $error("counter not fed from crossing path");
endmodule // tcar_turns_readout
